// *** logic/spi_core.sv ***
// SPI core: transmit queue, flags, partial reset, low power, pins
`timescale 1ns/1ns
`default_nettype none
module spi_core (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_link_sck,
   input wire logic i_ctrl_wr,
   input wire logic [7:0] i_ctrl_wdata,
   input wire logic i_sctrl_wr,
   input wire logic [3:0] i_sctrl_wdata,
   input wire logic i_stat_rd,
   input wire logic i_data_rd,
   input wire logic i_data_wr,
   input wire logic [7:0] i_data_wdata,
   input wire logic i_wait,
   input wire logic i_stop,
   input wire logic i_break,
   input wire logic i_break_clear_permit,
   input wire logic i_ss_n,
   input wire logic i_miso,
   input wire logic i_mosi,
   output logic [7:0] o_ctrl,
   output logic [3:0] o_sctrl,
   output logic [7:0] o_rx_data,
   output logic o_tx_empty,
   output logic o_rx_full,
   output logic o_overrun,
   output logic o_mode_fault,
   output logic o_wake_req,
   output logic o_port_own,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe
);
   typedef enum logic {M_IDLE, M_SHIFT} mstate_e;
   localparam int TE_LAT = spi_pkg::TE_LATENCY_CYC;

   function automatic logic [4:0] half_load(input logic [1:0] sel);
      logic [4:0] h;
      h = spi_pkg::BAUD_HALF0;
      unique case (sel)
         2'h0: h = spi_pkg::BAUD_HALF0;
         2'h1: h = spi_pkg::BAUD_HALF1;
         2'h2: h = spi_pkg::BAUD_HALF2;
         2'h3: h = spi_pkg::BAUD_HALF3;
      endcase
      return h - 5'h01;
   endfunction

   logic [7:0] ctrl_ff;
   logic [3:0] sctrl_ff;
   logic [7:0] txbuf_ff;
   logic tx_empty_ff;
   logic [7:0] rxdata_ff;
   logic rx_full_ff;
   logic ovr_ff;
   logic mode_fault_flag_ff;
   logic rx_arm_ff;
   logic ovr_arm_ff;
   logic mode_fault_flag_arm_ff;
   mstate_e state_ff;
   logic [3:0] half_ff;
   logic [4:0] div_ff;
   logic [7:0] tsh_ff;
   logic [7:0] rsh_ff;
   logic sck_ff;
   logic mosi_ff;
   logic [7:0] slv_word_ff;
   logic done_seen_ff;
   logic drv_m_ff;
   logic miso_oe_ff;
   logic own_ff;
   logic wake_ff;
   logic [2:0] lk_cnt_ff;
   logic [7:0] lk_sh_ff;
   logic [7:0] lk_rx_ff;
   logic lk_done_tgl_ff;
   logic lk_miso_ff;
   logic ss_s;
   logic miso_s;
   logic done_s;

   // ************************************************************
   // Pin and link-event synchronisers
   // ************************************************************
   pin_sync3 #(.W(3)) u_sync (
      .i_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_d({i_ss_n, i_miso, lk_done_tgl_ff}),
      .o_q({ss_s, miso_s, done_s})
   );

   // ************************************************************
   // Decodes
   // ************************************************************
   logic en;
   logic master;
   logic cpha;
   logic wom;
   logic acc;
   logic clr_ok;
   logic wr_ok;
   logic mfault;
   logic tick;
   logic m_done;
   logic slv_done;
   logic load_m;
   logic load_s;
   logic rx_evt;
   logic [7:0] rx_word;
   logic rx_clr;
   logic ovr_clr;
   logic rx_take;
   logic lk_bit;
   logic lk_rst_n;

   assign en = ctrl_ff[spi_pkg::C_ENABLE];
   assign master = ctrl_ff[spi_pkg::C_MASTER];
   assign cpha = ctrl_ff[spi_pkg::C_CPHA];
   assign wom = ctrl_ff[spi_pkg::C_WIRED_OR];
   assign acc = ~i_wait;
   assign clr_ok = ~i_break | i_break_clear_permit;
   assign wr_ok = acc & i_data_wr & clr_ok;
   assign mfault = en & master & sctrl_ff[spi_pkg::S_MF_DET] & ~ss_s;
   assign tick = (state_ff == M_SHIFT) & ~i_stop & (div_ff == 5'h00);
   assign m_done = tick & (half_ff == spi_pkg::HALF_LAST);
   assign slv_done = done_s ^ done_seen_ff;
   assign load_m = en & master & ~i_stop & (state_ff == M_IDLE)
      & ~tx_empty_ff;
   assign load_s = en & ~master & ~tx_empty_ff
      & (ss_s | slv_done);
   assign rx_evt = en & (master ? m_done : slv_done);
   // Last sample edge of phase one coincides with the final tick
   assign rx_word = master ?
      (cpha ? {rsh_ff[6:0], miso_s} : rsh_ff) : lk_rx_ff;
   assign rx_clr = acc & clr_ok & i_data_rd & rx_arm_ff;
   assign ovr_clr = acc & clr_ok & i_data_rd & ovr_arm_ff;
   assign rx_take = rx_evt & ~ovr_ff & (~rx_full_ff | rx_clr);

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_ff <= spi_pkg::CTRL_RST;
         sctrl_ff <= spi_pkg::SCTRL_RST;
      end else begin
         if (acc & i_ctrl_wr) begin
            ctrl_ff <= i_ctrl_wdata;
         end
         if (acc & i_sctrl_wr) begin
            sctrl_ff <= i_sctrl_wdata;
         end
         if (mfault) begin
            ctrl_ff[spi_pkg::C_ENABLE] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Transmit buffer and empty flag
   // ************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         txbuf_ff <= 8'h00;
         tx_empty_ff <= 1'b1;
      end else begin
         if (wr_ok) begin
            txbuf_ff <= i_data_wdata;
         end
         if (!en) begin
            tx_empty_ff <= 1'b1;
         end else if (wr_ok) begin
            tx_empty_ff <= 1'b0;
         end else if (load_m | load_s) begin
            tx_empty_ff <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Receive data and flags
   // ************************************************************
   // Flags survive enable low; only system reset or the two-step read clears them
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rxdata_ff <= 8'h00;
         rx_full_ff <= 1'b0;
         ovr_ff <= 1'b0;
      end else begin
         if (rx_take) begin
            rxdata_ff <= rx_word;
            rx_full_ff <= 1'b1;
         end else if (rx_clr) begin
            rx_full_ff <= 1'b0;
         end
         if (rx_evt & ~rx_take) begin
            ovr_ff <= 1'b1;
         end else if (ovr_clr) begin
            ovr_ff <= 1'b0;
         end
      end
   end

   // First step of each two-step clear; frozen while clears are barred
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_arm_ff <= 1'b0;
         ovr_arm_ff <= 1'b0;
         mode_fault_flag_arm_ff <= 1'b0;
      end else if (acc & clr_ok) begin
         if (i_stat_rd & rx_full_ff) begin
            rx_arm_ff <= 1'b1;
         end else if (i_data_rd) begin
            rx_arm_ff <= 1'b0;
         end
         if (i_stat_rd & ovr_ff) begin
            ovr_arm_ff <= 1'b1;
         end else if (i_data_rd) begin
            ovr_arm_ff <= 1'b0;
         end
         if (i_stat_rd & mode_fault_flag_ff) begin
            mode_fault_flag_arm_ff <= 1'b1;
         end else if (i_ctrl_wr) begin
            mode_fault_flag_arm_ff <= 1'b0;
         end
      end
   end

   // A fault present during the clearing write keeps the flag set
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mode_fault_flag_ff <= 1'b0;
      end else if (mfault) begin
         mode_fault_flag_ff <= 1'b1;
      end else if (acc & clr_ok & i_ctrl_wr & mode_fault_flag_arm_ff) begin
         mode_fault_flag_ff <= 1'b0;
      end
   end

   // ************************************************************
   // Master shifter and clock divider
   // ************************************************************
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= M_IDLE;
         half_ff <= 4'h0;
         div_ff <= 5'h00;
         tsh_ff <= 8'h00;
         rsh_ff <= 8'h00;
         sck_ff <= 1'b0;
         mosi_ff <= 1'b0;
      end else if (!en) begin
         state_ff <= M_IDLE;
         half_ff <= 4'h0;
         div_ff <= 5'h00;
         tsh_ff <= 8'h00;
         rsh_ff <= 8'h00;
         sck_ff <= ctrl_ff[spi_pkg::C_CPOL];
         mosi_ff <= 1'b0;
      end else if (load_m) begin
         state_ff <= M_SHIFT;
         half_ff <= 4'h0;
         div_ff <= half_load(sctrl_ff[1:0]);
         sck_ff <= ctrl_ff[spi_pkg::C_CPOL];
         if (cpha) begin
            tsh_ff <= txbuf_ff;
         end else begin
            mosi_ff <= txbuf_ff[7];
            tsh_ff <= {txbuf_ff[6:0], 1'b0};
         end
      end else if (tick) begin
         div_ff <= half_load(sctrl_ff[1:0]);
         sck_ff <= ~sck_ff;
         half_ff <= half_ff + 4'h1;
         if (half_ff[0] == cpha) begin
            rsh_ff <= {rsh_ff[6:0], miso_s};
         end else begin
            mosi_ff <= tsh_ff[7];
            tsh_ff <= {tsh_ff[6:0], 1'b0};
         end
         if (half_ff == spi_pkg::HALF_LAST) begin
            state_ff <= M_IDLE;
         end
      end else if (state_ff == M_SHIFT) begin
         if (!i_stop) begin
            div_ff <= div_ff - 5'h01;
         end
      end else begin
         sck_ff <= ctrl_ff[spi_pkg::C_CPOL];
      end
   end

   // ************************************************************
   // Slave word hand-off and pin control
   // ************************************************************
   // Word is only loaded while deselected or just after a byte ends; enable low clears it to zero
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         slv_word_ff <= 8'h00;
         done_seen_ff <= 1'b0;
      end else begin
         done_seen_ff <= done_s;
         if (!en) begin
            slv_word_ff <= 8'h00;
         end else if (load_s) begin
            slv_word_ff <= txbuf_ff;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         own_ff <= 1'b0;
         drv_m_ff <= 1'b0;
         miso_oe_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         own_ff <= en;
         drv_m_ff <= en & master;
         miso_oe_ff <= en & ~master & ~ss_s;
         wake_ff <= (en & ctrl_ff[spi_pkg::C_RX_IE] & rx_full_ff)
            | (ctrl_ff[spi_pkg::C_TX_IE] & tx_empty_ff)
            | (sctrl_ff[spi_pkg::S_ERR_IE] & (ovr_ff | mode_fault_flag_ff));
      end
   end

   // ************************************************************
   // Slave link domain
   // ************************************************************
   // Samples on the rising link edge only; select high aborts the byte
   assign lk_rst_n = i_rstn & en & ~master & ~i_ss_n;

   always_ff @(posedge i_link_sck or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_cnt_ff <= 3'h0;
         lk_sh_ff <= 8'h00;
      end else begin
         lk_cnt_ff <= lk_cnt_ff + 3'h1;
         if (lk_cnt_ff == 3'h0) begin
            lk_sh_ff <= {slv_word_ff[6:0], i_mosi};
         end else begin
            lk_sh_ff <= {lk_sh_ff[6:0], i_mosi};
         end
      end
   end

   // Toggle outlives link resets so the event count stays paired
   always_ff @(posedge i_link_sck or negedge i_rstn) begin
      if (!i_rstn) begin
         lk_rx_ff <= 8'h00;
         lk_done_tgl_ff <= 1'b0;
      end else if (lk_rst_n && lk_cnt_ff == 3'h7) begin
         lk_rx_ff <= {lk_sh_ff[6:0], i_mosi};
         lk_done_tgl_ff <= ~lk_done_tgl_ff;
      end
   end

   always_ff @(negedge i_link_sck or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_miso_ff <= 1'b0;
      end else begin
         lk_miso_ff <= lk_sh_ff[7];
      end
   end

   // Hazard: a link edge within a few reference cycles of a byte end
   // may still see the previous word's first bit
   assign lk_bit = (lk_cnt_ff == 3'h0) ? slv_word_ff[7] : lk_miso_ff;

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_ctrl = ctrl_ff;
   assign o_sctrl = sctrl_ff;
   assign o_rx_data = rxdata_ff;
   assign o_tx_empty = tx_empty_ff;
   assign o_rx_full = rx_full_ff;
   assign o_overrun = ovr_ff;
   assign o_mode_fault = mode_fault_flag_ff;
   assign o_wake_req = wake_ff;
   assign o_port_own = own_ff;
   assign o_sck = wom ? 1'b0 : sck_ff;
   assign o_sck_oe = drv_m_ff & (~wom | ~sck_ff);
   assign o_mosi = wom ? 1'b0 : mosi_ff;
   assign o_mosi_oe = drv_m_ff & (~wom | ~mosi_ff);
   assign o_miso = wom ? 1'b0 : lk_bit;
   assign o_miso_oe = miso_oe_ff & (~wom | ~lk_bit);

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [4:0] edge_cnt_ff;
   logic sck_q_ff;
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         edge_cnt_ff <= 5'h00;
         sck_q_ff <= 1'b0;
      end else begin
         sck_q_ff <= sck_ff;
         if (load_m) begin
            edge_cnt_ff <= 5'h00;
         end else if (state_ff == M_SHIFT || sck_ff != sck_q_ff) begin
            edge_cnt_ff <= edge_cnt_ff + {4'h0, sck_ff != sck_q_ff};
         end
      end
   end

   sequence s_rx_armed;
      rx_full_ff && rx_arm_ff;
   endsequence
   sequence s_rx_read;
      acc && clr_ok && i_data_rd && !rx_evt;
   endsequence

   a_te_refill: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      (load_m || load_s) && !wr_ok |-> ##[1:TE_LAT] tx_empty_ff)
      else $error("transmit empty not set after shifter load");
   a_wr_clears_te: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      wr_ok && en && !mfault |=> !tx_empty_ff)
      else $error("data write did not clear transmit empty");
   a_byte_edges: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(state_ff == M_SHIFT) && en
      |-> edge_cnt_ff == 5'h0F && sck_ff != sck_q_ff)
      else $error("master byte did not take sixteen clock edges");
   a_rx_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      rx_evt && !ovr_ff && !rx_full_ff
      |=> rx_full_ff && rxdata_ff == $past(rx_word))
      else $error("received byte did not set rx full");
   a_rx_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      s_rx_armed ##0 s_rx_read |=> !rx_full_ff)
      else $error("two-step read did not clear rx full");
   a_dis_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      !en |=> tx_empty_ff && state_ff == M_IDLE && tsh_ff == 8'h00)
      else $error("disabled core not idle");
   a_dis_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(en) && !$past(i_sctrl_wr) |-> sctrl_ff == $past(sctrl_ff))
      else $error("disable changed status control bits");
   a_fault_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      mfault |=> !en && mode_fault_flag_ff ##1 tx_empty_ff)
      else $error("mode fault did not disable the core");
   a_break_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      i_break && !i_break_clear_permit && rx_full_ff |=> rx_full_ff)
      else $error("rx full cleared during protected break");
   a_break_write: assert property (@(posedge i_ref_clk)
      disable iff (!i_rstn)
      i_break && !i_break_clear_permit && i_data_wr && tx_empty_ff && en
      |=> tx_empty_ff && $stable(txbuf_ff))
      else $error("data write acted during protected break");
   a_miso_hiz: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
      ss_s || master |=> !o_miso_oe)
      else $error("slave output driven while not selected");
   a_reset_master: assert property (@(posedge i_ref_clk)
      $rose(i_rstn) |-> master && !en)
      else $error("core not master after reset");
endmodule
`default_nettype wire

// *** logic/spi_pkg.sv ***
// Shared constants for the SPI core
package spi_pkg;
   // ************************************************************
   // Data and control layout
   // ************************************************************
   localparam int BYTE_W = 8;
   localparam logic [3:0] HALF_LAST = 4'hF;
   localparam int C_RX_IE = 7;
   localparam int C_MASTER = 5;
   localparam int C_CPOL = 4;
   localparam int C_CPHA = 3;
   localparam int C_WIRED_OR = 2;
   localparam int C_ENABLE = 1;
   localparam int C_TX_IE = 0;
   localparam logic [7:0] CTRL_RST = 8'h28;
   localparam int S_ERR_IE = 3;
   localparam int S_MF_DET = 2;
   localparam int S_BAUD_HI = 1;
   localparam int S_BAUD_LO = 0;
   localparam logic [3:0] SCTRL_RST = 4'h0;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam logic [4:0] BAUD_HALF0 = 5'h01;
   localparam logic [4:0] BAUD_HALF1 = 5'h04;
   localparam logic [4:0] BAUD_HALF2 = 5'h08;
   localparam logic [4:0] BAUD_HALF3 = 5'h10;
   localparam int REF_PERIOD_NS = 8;
   localparam int TE_LATENCY_NS = 16;
   localparam int TE_LATENCY_CYC = (TE_LATENCY_NS / REF_PERIOD_NS < 1) ?
      1 : TE_LATENCY_NS / REF_PERIOD_NS;
endpackage

// *** logic/pin_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   // A bit moves only once stages two and three agree
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         o_q <= '0;
      end else begin
         s1_ff <= i_d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         o_q <= (s3_ff & ~(s2_ff ^ s3_ff)) | (o_q & (s2_ff ^ s3_ff));
      end
   end
endmodule
`default_nettype wire

// *** sim/spi_far_slave.sv ***
// Far-end SPI slave model, clock phase one, polarity zero
`timescale 1ns/1ns
`default_nettype none
module spi_far_slave (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic [7:0] i_tx_byte,
   output logic o_miso,
   output logic [7:0] o_rx_byte
);
   int bit_cnt = 0;
   logic [7:0] shift_out = 8'h00;
   initial o_miso = 1'b0;
   initial o_rx_byte = 8'h00;
   // Leading edge launches the next bit
   always @(posedge i_sck) begin
      if (bit_cnt == 0)
         shift_out = i_tx_byte;
      o_miso <= shift_out[7 - bit_cnt];
   end
   // Line scrambled after the byte so a stale bit never looks valid
   always @(negedge i_sck) begin
      o_rx_byte <= {o_rx_byte[6:0], i_mosi};
      bit_cnt = (bit_cnt + 1) % 8;
      if (bit_cnt == 0)
         o_miso <= ~o_miso;
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the SPI core against a far-end slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_link_sck = 1'b0;
   logic i_ctrl_wr = 1'b0, i_sctrl_wr = 1'b0, i_stat_rd = 1'b0;
   logic i_data_rd = 1'b0, i_data_wr = 1'b0, i_wait = 1'b0;
   logic i_stop = 1'b0, i_break = 1'b0, i_permit = 1'b0;
   logic i_ss_n = 1'b1, i_mosi = 1'b0;
   logic [7:0] i_ctrl_wdata = 8'h28, i_data_wdata = 8'h00, miso_got;
   logic [3:0] i_sctrl_wdata = 4'h0, o_sctrl;
   logic [7:0] o_ctrl, o_rx_data, far_rx;
   logic o_tx_empty, o_rx_full, o_mode_fault, o_port_own;
   logic o_sck, o_mosi, o_mosi_oe, o_miso, o_miso_oe, far_miso, o_sck_oe;
   localparam logic [7:0] SLV_IN = 8'h69;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   always #4 i_ref_clk = ~i_ref_clk;
   spi_core dut (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_link_sck(i_link_sck),
      .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
      .i_sctrl_wr(i_sctrl_wr), .i_sctrl_wdata(i_sctrl_wdata),
      .i_stat_rd(i_stat_rd), .i_data_rd(i_data_rd), .i_data_wr(i_data_wr),
      .i_data_wdata(i_data_wdata), .i_wait(i_wait), .i_stop(i_stop),
      .i_break(i_break), .i_break_clear_permit(i_permit),
      .i_ss_n(i_ss_n), .i_miso(far_miso), .i_mosi(i_mosi),
      .o_ctrl(o_ctrl), .o_sctrl(o_sctrl), .o_rx_data(o_rx_data),
      .o_tx_empty(o_tx_empty), .o_rx_full(o_rx_full), .o_overrun(),
      .o_mode_fault(o_mode_fault), .o_wake_req(), .o_port_own(o_port_own),
      .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_mosi(o_mosi),
      .o_mosi_oe(o_mosi_oe),
      .o_miso(o_miso), .o_miso_oe(o_miso_oe));
   spi_far_slave far (.i_sck(o_sck), .i_mosi(o_mosi), .i_tx_byte(8'h5A),
      .o_miso(far_miso), .o_rx_byte(far_rx));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bounded cycle budget so a stuck flag cannot hang the run
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         end_sim();
      end
   end
   // ****************************************
   // Strobe drivers
   // ****************************************
   task automatic wr_ctrl(input logic [7:0] v);
      @(posedge i_ref_clk);
      i_ctrl_wr <= 1'b1;
      i_ctrl_wdata <= v;
      @(posedge i_ref_clk);
      i_ctrl_wr <= 1'b0;
   endtask
   task automatic wr_sctrl(input logic [3:0] v);
      @(posedge i_ref_clk);
      i_sctrl_wr <= 1'b1;
      i_sctrl_wdata <= v;
      @(posedge i_ref_clk);
      i_sctrl_wr <= 1'b0;
   endtask
   task automatic wr_data(input logic [7:0] v);
      @(posedge i_ref_clk);
      i_data_wr <= 1'b1;
      i_data_wdata <= v;
      @(posedge i_ref_clk);
      i_data_wr <= 1'b0;
   endtask
   task automatic rd_stat();
      @(posedge i_ref_clk);
      i_stat_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_stat_rd <= 1'b0;
   endtask
   task automatic rd_data();
      @(posedge i_ref_clk);
      i_data_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_data_rd <= 1'b0;
   endtask
   task automatic wait_rx();
      for (n = 0; n < 700 && o_rx_full !== 1'b1; n++)
         @(posedge i_ref_clk);
      #1;
   endtask
   // Flags answer at the taking edge; check them one cycle later
   task automatic flags_next(input logic [1:0] exp);
      @(posedge i_ref_clk);
      #1 chk({6'h0, o_tx_empty, o_rx_full}, {6'h0, exp});
   endtask
   task automatic t_master();
      wr_sctrl(4'h3);
      wr_ctrl(8'h2A);
      wr_data(8'hA5);
      // Shifter load follows one edge later, so look right after the write
      #1 chk({6'h0, o_tx_empty, o_rx_full}, 8'h00);
      repeat (2) @(posedge i_ref_clk);
      #1 chk({7'h0, o_tx_empty}, 8'h01);
      chk({6'h0, o_port_own, o_sck_oe}, 8'h03);
      wr_data(8'h3C);
      wait_rx();
      chk(o_rx_data, 8'h5A);
      chk(far_rx, 8'hA5);
      repeat (3) @(posedge i_ref_clk);
      #1 chk({7'h0, o_tx_empty}, 8'h01);
      rd_stat();
      rd_data();
      flags_next(2'b10);
      wait_rx();
      chk(far_rx, 8'h3C);
      $display("master test done");
   endtask
   task automatic t_disable_break();
      wr_ctrl(8'h28);
      // Pin ownership flops follow the enable bit one edge later
      @(posedge i_ref_clk);
      #1 chk({o_sctrl, o_rx_full, o_tx_empty, o_port_own, o_mosi_oe},
         8'h3C);
      wr_ctrl(8'h2A);
      rd_stat();
      i_break <= 1'b1;
      rd_data();
      wr_data(8'h77);
      flags_next(2'b11);
      i_break <= 1'b0;
      rd_data();
      flags_next(2'b10);
      i_wait <= 1'b1;
      wr_data(8'h11);
      flags_next(2'b10);
      i_wait <= 1'b0;
      $display("disable and break test done");
   endtask
   task automatic t_fault_slave();
      wr_sctrl(4'h7);
      i_ss_n <= 1'b0;
      repeat (8) @(posedge i_ref_clk);
      #1 chk({6'h0, o_mode_fault, o_ctrl[1]}, 8'h02);
      i_ss_n <= 1'b1;
      wr_sctrl(4'h3);
      wr_ctrl(8'h0A);
      wr_data(8'h96);
      repeat (4) @(posedge i_ref_clk);
      #1 chk({7'h0, o_miso_oe}, 8'h00);
      i_ss_n <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
      #1 chk({7'h0, o_miso_oe}, 8'h01);
      for (n = 7; n >= 0; n--) begin
         i_mosi = SLV_IN[n];
         #16 miso_got = {miso_got[6:0], o_miso};
         i_link_sck = 1'b1;
         #16 i_link_sck = 1'b0;
      end
      wait_rx();
      chk(o_rx_data, SLV_IN);
      chk(miso_got, 8'h96);
      $display("fault and slave test done");
   endtask
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      #1 chk(o_ctrl, 8'h28);
      chk({o_sctrl, o_tx_empty, o_rx_full, o_mosi_oe, o_miso_oe},
         8'h08);
      $display("reset test done");
      t_master();
      t_disable_break();
      t_fault_slave();
      end_sim();
   end
endmodule
`default_nettype wire
